//--- verilog/flash_rewrite_defines.svh
// Register indices, bit positions, reset values and timing counts of the flash rewrite control
`ifndef FLASH_REWRITE_DEFINES_SVH
`define FLASH_REWRITE_DEFINES_SVH

// Register indices; the byte address on the bus is four times the index
`define FLASH_STATUS_IDX       10'h1b2
`define FLASH_CONTROL_ZERO_IDX 10'h1b4

// Status bit positions
`define ST_RDY_IRQ   0
`define ST_ACC_ERR   1
`define ST_LOCK      2
`define ST_UNUSED    3
`define ST_PROG_ERR  4
`define ST_ERASE_ERR 5
`define ST_SUSPEND   6
`define ST_READY     7

// Control bit positions
`define CT_REWRITE   1
`define CT_SUBMODE   2
`define CT_STOP      3
`define CT_SEQ_RST   4
`define CT_ERR_IE    5
`define CT_ACC_IE    6
`define CT_RDY_IE    7

// Reset values
`define CONTROL_RESET 8'h00
`define LOCK_RESET    1'b1

// Timing
`define CLK_PERIOD_NS   25
`define TERM_DELAY_NS   1000
`define POWER_DELAY_NS  1000
`define TERM_CYC  ((`TERM_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define POWER_CYC ((`POWER_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

//--- verilog/flash_rewrite_pkg.sv
// Types shared between the flash rewrite control and the flash sequencer core
package flash_rewrite_pkg;

  // Events from the sequencer core, each a one-cycle pulse except lock_bit
  typedef struct packed {
    logic cmd_start;
    logic cmd_done;
    logic lock_upd;
    logic lock_bit;
    logic prog_err;
    logic erase_err;
    logic blank_err;
    logic cmd_err;
    logic suspend_ack;
    logic suspend_exit;
    logic clr_status;
    logic busy_area_acc;
    logic dflash_rd_rom;
  } seq_evt_t;

  // Controls toward the sequencer core
  typedef struct packed {
    logic rewrite_enable;
    logic submode_select;
    logic flash_stopped;
    logic seq_abort;
  } seq_ctl_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_CMD,
    ST_ABORT,
    ST_POWER
  } seq_state_t;

endpackage : flash_rewrite_pkg

//--- verilog/arm_bit.sv
// Control bit that is set only by a write of 0 immediately followed by a write of 1
`timescale 1ns/10ps
module arm_bit (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic ce_i,
  input  wire logic wr_i,
  input  wire logic other_wr_i,
  input  wire logic bit_i,
  output logic      val_o
);
  logic armed_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      armed_r <= 1'b0;
      val_o   <= 1'b0;
    end else if (ce_i) begin
      if (wr_i) begin
        armed_r <= ~bit_i;
        if (!bit_i)
          val_o <= 1'b0;
        else if (armed_r)
          val_o <= 1'b1;
      end else if (other_wr_i) begin
        armed_r <= 1'b0;
      end
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i || !ce_i);

  arm_needed_a: assert property ($rose(val_o) |-> $past(armed_r) && $past(wr_i))
    else $error("bit set without a preceding write of 0");
  arm_clear_a: assert property (wr_i && !bit_i |=> !val_o && armed_r)
    else $error("write of 0 did not clear and arm the bit");
endmodule : arm_bit

//--- verilog/flash_rewrite_status_control.sv
// Status and control registers of the flash rewrite sequencer, with a classic Wishbone slave
//
// Functional notes
// - Ready flag reads busy during any command, forced stop, flash stop or wake.
// - Suspend flag is one only while an acknowledged erase-suspend is pending.
// - Program error flag records an automatic programming failure.
// - Erase error flag records an erase or blank check failure.
// - A command error sets both error flags.
// - With ready interrupt enabled, every busy-to-ready change sets ready request flag.
// - Software cannot set the ready request flag; writing zero clears it.
// - With access interrupt enabled, touching the busy area sets the access error flag.
// - Reading data flash during program ROM rewrite also sets access error.
// - With error interrupt enabled, any command error sets the access error flag.
// - Access error clears by writing zero or clear status; writing one does nothing.
// - Lock monitor captures lock state at command completion and holds it.
// - Status bit 3 always reads zero.
// - Control bit 1 enables rewrite mode; bit 2 selects the second sub-mode.
// - Rewrite enable and sub-mode set only by write 0 then immediately write 1.
// - Flash stop bit acts only in rewrite mode; software sets it while ready.
// - Sequence reset honoured only in rewrite mode while busy.
// - Control bits 5, 6, 7 enable error, access and ready interrupts; reset zero.
// - Suspend clears as soon as a forced stop is accepted; after the termination delay the command ends, reads resume.
`timescale 1ns/10ps
`include "flash_rewrite_defines.svh"
module flash_rewrite_status_control #(
  parameter int CNT_W = 8
) (
  input  wire logic                        clk_i,
  input  wire logic                        rst_i,
  input  wire logic                        ce_i,
  input  wire logic                        wb_cyc_i,
  input  wire logic                        wb_stb_i,
  input  wire logic                        wb_we_i,
  input  wire logic [11:0]                 wb_adr_i,
  input  wire logic [3:0]                  wb_sel_i,
  input  wire logic [31:0]                 wb_dat_i,
  output logic      [31:0]                 wb_dat_o,
  output logic                             wb_ack_o,
  input  wire flash_rewrite_pkg::seq_evt_t evt_i,
  output flash_rewrite_pkg::seq_ctl_t      ctl_o,
  output logic                             irq_o
);
  import flash_rewrite_pkg::*;

  localparam logic [CNT_W-1:0] TERM_CYC  = CNT_W'(`TERM_CYC);
  localparam logic [CNT_W-1:0] POWER_CYC = CNT_W'(`POWER_CYC);
  localparam int               TERM_GAP  = `TERM_CYC - 8;

  seq_state_t       state_r;
  logic [CNT_W-1:0] cnt_r;
  logic             stopped_r;
  logic             rdy_q_r;
  logic             suspend_r;
  logic             prog_err_r;
  logic             erase_err_r;
  logic             lock_r;
  logic             rdy_irq_r;
  logic             acc_err_r;
  logic             stop_r;
  logic             err_ie_r;
  logic             acc_ie_r;
  logic             rdy_ie_r;
  logic             abort_r;
  logic             ack_r;
  logic [31:0]      dat_r;
  logic [1:0]       armed_val;

  logic       hit;
  logic       wr;
  logic       wr_st;
  logic       wr_ct;
  logic       sel_st;
  logic       sel_ct;
  logic       ready;
  logic       stop_eff;
  logic       abort_req;
  logic       rdy_evt;
  logic       acc_set;
  logic [7:0] st_byte;
  logic [7:0] ct_byte;

  // Bus decode
  assign hit    = wb_cyc_i & wb_stb_i & ~ack_r;
  assign sel_st = (wb_adr_i[11:2] == `FLASH_STATUS_IDX);
  assign sel_ct = (wb_adr_i[11:2] == `FLASH_CONTROL_ZERO_IDX);
  assign wr     = hit & wb_we_i & wb_sel_i[0];
  assign wr_st  = wr & sel_st;
  assign wr_ct  = wr & sel_ct;

  assign ready    = (state_r == ST_IDLE);
  assign stop_eff = stop_r & armed_val[0];
  assign abort_req = wr_ct & wb_dat_i[`CT_SEQ_RST] & armed_val[0] & ~ready
                     & (state_r != ST_ABORT);
  assign rdy_evt  = rdy_ie_r & ready & ~rdy_q_r;
  assign acc_set  = (acc_ie_r & ~ready & evt_i.busy_area_acc)
                  | (acc_ie_r & ~ready & evt_i.dflash_rd_rom)
                  | (err_ie_r & (evt_i.cmd_err | evt_i.erase_err
                                 | evt_i.blank_err | evt_i.prog_err));

  always_comb begin
    st_byte = 8'h00;
    st_byte[`ST_RDY_IRQ]   = rdy_irq_r;
    st_byte[`ST_ACC_ERR]   = acc_err_r;
    st_byte[`ST_LOCK]      = lock_r;
    st_byte[`ST_UNUSED]    = 1'b0;
    st_byte[`ST_PROG_ERR]  = prog_err_r;
    st_byte[`ST_ERASE_ERR] = erase_err_r;
    st_byte[`ST_SUSPEND]   = suspend_r;
    st_byte[`ST_READY]     = ready;
  end

  always_comb begin
    ct_byte = 8'h00;
    ct_byte[`CT_REWRITE] = armed_val[0];
    ct_byte[`CT_SUBMODE] = armed_val[1];
    ct_byte[`CT_STOP]    = stop_r;
    ct_byte[`CT_SEQ_RST] = 1'b0;
    ct_byte[`CT_ERR_IE]  = err_ie_r;
    ct_byte[`CT_ACC_IE]  = acc_ie_r;
    ct_byte[`CT_RDY_IE]  = rdy_ie_r;
  end

  // Wishbone answer: one wait state, unmapped addresses read zero, and a write to them only cancels a pending write of 0 to the arm bits
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
      dat_r <= 32'h0000_0000;
    end else if (ce_i) begin
      ack_r <= hit;
      if (hit)
        dat_r <= sel_st ? {24'h00_0000, st_byte} :
                 sel_ct ? {24'h00_0000, ct_byte} : 32'h0000_0000;
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;

  // Rewrite enable and sub-mode select
  for (genvar g = 0; g < 2; g++) begin : g_arm
    arm_bit u_arm (
      .clk_i      (clk_i),
      .rst_i      (rst_i),
      .ce_i       (ce_i),
      .wr_i       (wr_ct),
      .other_wr_i (wr_st | (hit & wb_we_i & ~sel_ct)),
      .bit_i      (wb_dat_i[`CT_REWRITE + g]),
      .val_o      (armed_val[g])
    );
  end

  // Plain control bits
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      {rdy_ie_r, acc_ie_r, err_ie_r} <= 3'b000;
      stop_r                          <= 1'b0;
    end else if (ce_i && wr_ct) begin
      rdy_ie_r <= wb_dat_i[`CT_RDY_IE];
      acc_ie_r <= wb_dat_i[`CT_ACC_IE];
      err_ie_r <= wb_dat_i[`CT_ERR_IE];
      stop_r   <= wb_dat_i[`CT_STOP];
    end
  end

  // Sequencer busy state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r   <= ST_IDLE;
      cnt_r     <= '0;
      stopped_r <= 1'b0;
    end else if (ce_i) begin
      if (abort_req) begin
        state_r <= ST_ABORT;
        cnt_r   <= TERM_CYC;
      end else begin
        case (state_r)
          ST_IDLE: begin
            if (stop_eff != stopped_r) begin
              state_r <= ST_POWER;
              cnt_r   <= POWER_CYC;
            end else if (evt_i.cmd_start && armed_val[0] && !stopped_r) begin
              state_r <= ST_CMD;
            end
          end
          ST_CMD: begin
            if (evt_i.cmd_done || evt_i.suspend_ack)
              state_r <= ST_IDLE;
          end
          ST_ABORT: begin
            if (cnt_r <= 1)
              state_r <= ST_IDLE;
            else
              cnt_r <= cnt_r - 1'b1;
          end
          ST_POWER: begin
            if (cnt_r <= 1) begin
              stopped_r <= stop_eff;
              state_r   <= ST_IDLE;
            end else begin
              cnt_r <= cnt_r - 1'b1;
            end
          end
          default: state_r <= ST_IDLE;
        endcase
      end
    end
  end

  // Ready history and abort pulse
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdy_q_r <= 1'b1;
      abort_r <= 1'b0;
    end else if (ce_i) begin
      rdy_q_r <= ready;
      abort_r <= abort_req;
    end
  end

  // Erase-suspend status
  always_ff @(posedge clk_i) begin
    if (rst_i)
      suspend_r <= 1'b0;
    else if (ce_i) begin
      if (abort_req)
        suspend_r <= 1'b0;
      else if (state_r == ST_CMD && evt_i.suspend_ack)
        suspend_r <= 1'b1;
      else if (evt_i.suspend_exit)
        suspend_r <= 1'b0;
    end
  end

  // Error flags, cleared by the clear status command; a new error wins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prog_err_r  <= 1'b0;
      erase_err_r <= 1'b0;
    end else if (ce_i) begin
      if (evt_i.prog_err || evt_i.cmd_err)
        prog_err_r <= 1'b1;
      else if (evt_i.clr_status)
        prog_err_r <= 1'b0;
      if (evt_i.erase_err || evt_i.blank_err || evt_i.cmd_err)
        erase_err_r <= 1'b1;
      else if (evt_i.clr_status)
        erase_err_r <= 1'b0;
    end
  end

  // Lock monitor
  always_ff @(posedge clk_i) begin
    if (rst_i)
      lock_r <= `LOCK_RESET;
    else if (ce_i && state_r == ST_CMD && evt_i.cmd_done && evt_i.lock_upd)
      lock_r <= evt_i.lock_bit;
  end

  // Interrupt request flags; hardware set wins over a clear in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdy_irq_r <= 1'b0;
      acc_err_r <= 1'b0;
    end else if (ce_i) begin
      if (rdy_evt)
        rdy_irq_r <= 1'b1;
      else if (wr_st && !wb_dat_i[`ST_RDY_IRQ])
        rdy_irq_r <= 1'b0;
      if (acc_set)
        acc_err_r <= 1'b1;
      else if (evt_i.clr_status || (wr_st && !wb_dat_i[`ST_ACC_ERR]))
        acc_err_r <= 1'b0;
    end
  end

  assign irq_o = rdy_irq_r | acc_err_r;

  always_comb begin
    ctl_o                = '0;
    ctl_o.rewrite_enable = armed_val[0];
    ctl_o.submode_select = armed_val[1];
    ctl_o.flash_stopped  = stopped_r;
    ctl_o.seq_abort      = abort_r;
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i || !ce_i);

  busy_on_start_a: assert property (ready && evt_i.cmd_start && armed_val[0] && !stopped_r
      && stop_eff == stopped_r && !abort_req |=> !st_byte[`ST_READY])
    else $error("command start did not show busy");
  suspend_set_a: assert property (state_r == ST_CMD && evt_i.suspend_ack && !abort_req
      |=> suspend_r && ready)
    else $error("suspend acknowledge not reported");
  prog_err_a: assert property (evt_i.prog_err |=> prog_err_r)
    else $error("program error not recorded");
  erase_err_a: assert property (evt_i.erase_err || evt_i.blank_err |=> erase_err_r)
    else $error("erase or blank check error not recorded");
  cmd_err_a: assert property (evt_i.cmd_err |=> prog_err_r && erase_err_r)
    else $error("command error did not set both flags");
  rdy_irq_set_a: assert property (!ready ##1 ready && rdy_ie_r |=> rdy_irq_r)
    else $error("busy to ready did not raise ready request");
  rdy_irq_w1_a: assert property (wr_st && wb_dat_i[`ST_RDY_IRQ] && !rdy_irq_r && !rdy_evt
      |=> !rdy_irq_r)
    else $error("software set the ready request flag");
  acc_busy_a: assert property (acc_ie_r && !ready && evt_i.busy_area_acc |=> acc_err_r)
    else $error("busy area access not flagged");
  acc_rom_a: assert property (acc_ie_r && !ready && evt_i.dflash_rd_rom |=> acc_err_r)
    else $error("data flash read during rewrite not flagged");
  err_to_acc_a: assert property (err_ie_r && evt_i.cmd_err |=> acc_err_r)
    else $error("command error not flagged as access error");
  acc_clear_a: assert property (wr_st && !wb_dat_i[`ST_ACC_ERR] && !acc_set
      |=> !acc_err_r)
    else $error("access error not cleared by write of zero");
  lock_hold_a: assert property (!(state_r == ST_CMD && evt_i.cmd_done)
      |=> $stable(lock_r))
    else $error("lock monitor changed outside command end");
  lock_cap_a: assert property (state_r == ST_CMD && evt_i.cmd_done && evt_i.lock_upd
      |=> lock_r == $past(evt_i.lock_bit))
    else $error("lock monitor did not capture the lock state");
  stop_refuse_a: assert property (stopped_r && ready && evt_i.cmd_start && stop_eff == stopped_r
      |=> ready)
    else $error("command accepted while the flash is stopped");
  abort_pulse_a: assert property (abort_req |=> ctl_o.seq_abort && !ready)
    else $error("accepted sequence reset gave no abort pulse");
  status_b3_a: assert property (wb_ack_o && sel_st && !wb_we_i
      |-> !wb_dat_o[`ST_UNUSED])
    else $error("unassigned status bit read one");
  abort_ignored_a: assert property (wr_ct && wb_dat_i[`CT_SEQ_RST] && (ready || !armed_val[0])
      |=> !ctl_o.seq_abort)
    else $error("sequence reset accepted while ready or outside rewrite mode");
  abort_term_a: assert property (abort_req |=> (!suspend_r && !ready) [*8] ##TERM_GAP !ready
      ##1 ready)
    else $error("forced termination did not end after the delay");
  irq_line_a: assert property ($rose(rdy_irq_r) || $rose(acc_err_r) |-> irq_o)
    else $error("interrupt output not raised");

  abort_seen_c: cover property (abort_req ##1 state_r == ST_ABORT);
  suspend_seen_c: cover property ($rose(suspend_r));
  stop_seen_c: cover property ($rose(stopped_r) ##[1:200] $fell(stopped_r));
  rdy_irq_seen_c: cover property ($rose(rdy_irq_r));
  suspend_abort_c: cover property (suspend_r && abort_req);
endmodule : flash_rewrite_status_control

//--- tb/flash_rewrite_status_control_bench.sv
// Self-checking bench for the flash rewrite status and control registers
`timescale 1ns/10ps
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin bad_count++; \
  $display("Error at %0t: got %h expected %h", $time, got, exp); end end
`define EV(f) begin e = '0; e.f = 1'b1; pulse(e); end
module flash_rewrite_status_control_bench;
  import flash_rewrite_pkg::*;
  localparam logic [11:0] ST = 12'h06c8;
  localparam logic [11:0] CT = 12'h06d0;
  typedef struct {logic w; logic [11:0] a; logic [7:0] d; logic [7:0] x;} row_t;
  logic        clk_i;
  logic        rst_i;
  logic        ce_i;
  logic        cyc;
  logic        stb;
  logic        we;
  logic [11:0] adr;
  logic [3:0]  sel;
  logic [31:0] wdat;
  logic [31:0] rdat;
  logic        ack;
  logic        irq;
  seq_evt_t    evt;
  seq_ctl_t    ctl;
  int          bad_count;
  int          check_count;
  int          abort_count = 0;
  row_t        rows [0:13];

  flash_rewrite_status_control u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .evt_i(evt), .ctl_o(ctl), .irq_o(irq)
  );

  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  always @(posedge clk_i) begin
    if (ctl.seq_abort === 1'b1) abort_count++;
  end

  task automatic print_verdict();
    $display("Checks %0d, errors %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : print_verdict

  // One classic cycle; held until ack is sampled high
  task automatic wb(input logic w, input logic [11:0] a, input logic [7:0] d,
                    output logic [7:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= {24'h00_0000, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    q = rdat[7:0];
    if (n >= 50) `CHK(1'b0, 1'b1)
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [7:0] q;
    wb(1'b1, a, d, q);
  endtask : wr

  task automatic rchk(input logic [11:0] a, input logic [7:0] x);
    logic [7:0] q;
    wb(1'b0, a, 8'h00, q);
    `CHK(q, x)
  endtask : rchk

  task automatic pulse(input seq_evt_t p);
    @(posedge clk_i);
    evt <= p;
    @(posedge clk_i);
    evt <= '0;
  endtask : pulse

  // Polls status until ready, bounded
  task automatic wait_ready();
    logic [7:0] q;
    int n;
    n = 0;
    do begin
      wb(1'b0, ST, 8'h00, q);
      n++;
    end while (q[7] !== 1'b1 && n < 60);
    if (n >= 60) `CHK(1'b0, 1'b1)
  endtask : wait_ready

  initial begin
    repeat (20000) @(posedge clk_i);
    bad_count++;
    print_verdict();
  end

  initial begin
    seq_evt_t   e;
    logic [7:0] q;
    logic [7:0] errx [0:3];
    bad_count = 0;
    check_count = 0;
    rst_i = 1'b1;
    ce_i = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 12'h000;
    sel = 4'h1;
    wdat = 32'h0000_0000;
    evt = '0;
    errx = '{8'h92, 8'ha2, 8'ha2, 8'hb2};
    rows = '{'{1, CT, 8'he0, 8'h00}, '{0, CT, 8'h00, 8'he0}, '{1, ST, 8'h00, 8'h00},
             '{1, CT, 8'he2, 8'h00}, '{0, CT, 8'h00, 8'he0}, '{1, CT, 8'he0, 8'h00},
             '{1, CT, 8'he6, 8'h00}, '{0, CT, 8'h00, 8'he6}, '{1, CT, 8'hf6, 8'h00},
             '{0, CT, 8'h00, 8'he6}, '{1, ST, 8'hff, 8'h00}, '{0, ST, 8'h00, 8'h84},
             '{1, 12'h000, 8'hff, 8'h00}, '{0, 12'h000, 8'h00, 8'h00}};
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    foreach (rows[i]) begin
      wb(rows[i].w, rows[i].a, rows[i].d, q);
      if (!rows[i].w) `CHK(q, rows[i].x)
    end
    `CHK({ctl.rewrite_enable, ctl.submode_select}, 2'b11)
    `CHK(abort_count, 0)
    // Command with access faults while busy
    `EV(cmd_start)
    rchk(ST, 8'h04);
    `EV(busy_area_acc)
    rchk(ST, 8'h06);
    `CHK(irq, 1'b1)
    wr(ST, 8'h01);
    rchk(ST, 8'h04);
    `EV(dflash_rd_rom)
    rchk(ST, 8'h06);
    wr(ST, 8'h00);
    e = '0;
    e.cmd_done = 1'b1;
    e.lock_upd = 1'b1;
    pulse(e);
    rchk(ST, 8'h81);
    `CHK(irq, 1'b1)
    wr(ST, 8'h00);
    rchk(ST, 8'h80);
    `CHK(irq, 1'b0)
    for (int k = 0; k < 4; k++) begin
      e = '0;
      case (k)
        0: e.prog_err = 1'b1;
        1: e.erase_err = 1'b1;
        2: e.blank_err = 1'b1;
        default: e.cmd_err = 1'b1;
      endcase
      pulse(e);
      rchk(ST, errx[k]);
      `EV(clr_status)
      rchk(ST, 8'h80);
    end
    // Suspend, then abort a command started during suspend
    `EV(cmd_start)
    `EV(suspend_ack)
    rchk(ST, 8'hc1);
    wr(ST, 8'h00);
    `EV(cmd_start)
    rchk(ST, 8'h40);
    wr(CT, 8'hf6);
    rchk(ST, 8'h00);
    `CHK(abort_count, 1)
    `CHK(rdat[7:0], 8'h00)
    wait_ready();
    rchk(ST, 8'h81);
    rchk(CT, 8'he6);
    wr(ST, 8'h00);
    // Suspend left by the core without an abort
    `EV(cmd_start)
    `EV(suspend_ack)
    `EV(suspend_exit)
    rchk(ST, 8'h81);
    wr(ST, 8'h00);
    // Flash stop and wake
    wr(CT, 8'hee);
    rchk(ST, 8'h00);
    wait_ready();
    `CHK(ctl.flash_stopped, 1'b1)
    `EV(cmd_start)
    rchk(ST, 8'h81);
    wr(ST, 8'h00);
    wr(CT, 8'he6);
    rchk(ST, 8'h00);
    wait_ready();
    `CHK(ctl.flash_stopped, 1'b0)
    // Clock enable low: a command start is not taken
    ce_i <= 1'b0;
    `EV(cmd_start)
    ce_i <= 1'b1;
    rchk(ST, 8'h81);
    // Reset in mid-run restores documented values
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    rchk(ST, 8'h84);
    rchk(CT, 8'h00);
    `CHK(ctl, 4'h0)
    `CHK(irq, 1'b0)
    print_verdict();
  end
endmodule : flash_rewrite_status_control_bench
